// ==== rtl/duty_div.sv ====
`timescale 1ns/1ps
`default_nettype none
module duty_div (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic reset_i,
    // Operands
    input wire logic start_i,
    input wire logic [31:0] dividend_i,
    input wire logic [15:0] divisor_i,
    // Result
    output logic done_o,
    output logic [15:0] quot_o
);
    import pwm_pkg::*;

    logic [5:0] cnt_r, cnt_nxt;
    logic busy_r, busy_nxt;
    logic done_r, done_nxt;
    logic [16:0] rem_r, rem_nxt;
    logic [31:0] q_r, q_nxt;
    logic [16:0] trial;

    // Restoring division, one quotient bit per clock
    always_comb begin
        cnt_nxt = cnt_r;
        busy_nxt = busy_r;
        rem_nxt = rem_r;
        q_nxt = q_r;
        done_nxt = 1'b0;
        trial = {rem_r[15:0], q_r[31]};
        if (start_i) begin
            cnt_nxt = '0;
            busy_nxt = 1'b1;
            rem_nxt = '0;
            q_nxt = dividend_i;
        end else if (busy_r) begin
            q_nxt = {q_r[30:0], 1'b0};
            if (trial >= {1'b0, divisor_i}) begin
                rem_nxt = trial - {1'b0, divisor_i};
                q_nxt[0] = 1'b1;
            end else begin
                rem_nxt = trial;
            end
            cnt_nxt = cnt_r + 6'h01;
            if (cnt_r == 6'(DIV_STEPS - 1)) begin
                busy_nxt = 1'b0;
                done_nxt = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            cnt_r <= '0;
            busy_r <= 1'b0;
            done_r <= 1'b0;
            rem_r <= '0;
            q_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
            busy_r <= busy_nxt;
            done_r <= done_nxt;
            rem_r <= rem_nxt;
            q_r <= q_nxt;
        end
    end

    assign done_o = done_r;
    assign quot_o = q_r[15:0];

    div_latency_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        start_i |-> ##33 done_o) else $error("divider result not on time");
endmodule : duty_div
`default_nettype wire

// ==== rtl/pwm_pkg.sv ====
`default_nettype none
package pwm_pkg;
    localparam int CLK_NS = 40;
    localparam int TB0_NS = 1000000;
    localparam int TB1_NS = 10000000;
    localparam int TB2_NS = 100000000;
    localparam int TB3_NS = 1000000000;
    localparam int PRE_W = 26;
    localparam int DIV_STEPS = 32;
    localparam int GAIN_SCALE = 100;

    localparam logic [7:0] ADR_CTRL = 8'h00;
    localparam logic [7:0] ADR_GAIN = 8'h04;
    localparam logic [7:0] ADR_OFFSET = 8'h08;
    localparam logic [7:0] ADR_LO = 8'h0c;
    localparam logic [7:0] ADR_HI = 8'h10;
    localparam logic [7:0] ADR_PERIOD = 8'h14;
    localparam logic [7:0] ADR_STATUS = 8'h18;
    localparam logic [7:0] ADR_WORK = 8'h1c;

    localparam int CTRL_SRC_B = 0;
    localparam int CTRL_TB_LSB = 1;
    localparam int CTRL_DEC_LSB = 4;
    localparam int STAT_PULSE_B = 0;
    localparam int STAT_RUN_B = 1;
    localparam int STAT_VALID_B = 2;

    localparam logic signed [15:0] GAIN_MAX = 16'h03e8;
    localparam logic signed [15:0] OFFS_MAX = 16'h2710;
    localparam logic signed [15:0] LIM_MAX = 16'h4e20;
    localparam logic [1:0] DEC_MAX = 2'h3;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {ST_IDLE, ST_CALC, ST_RUN} run_st_t;
    typedef enum logic [1:0] {CLS_LOW, CLS_MID, CLS_FULL} duty_cls_t;

    typedef struct packed {
        logic src;
        logic [1:0] tb;
        logic [1:0] dec;
        logic signed [15:0] gain;
        logic signed [15:0] offset;
        logic signed [15:0] lo;
        logic signed [15:0] hi;
        logic [15:0] period;
    } cfg_t;

    localparam cfg_t CFG_RST = '{src: 1'h0, tb: 2'h0, dec: 2'h0, gain: 16'h0064,
        offset: 16'h0000, lo: 16'h0000, hi: 16'h03e8, period: 16'h0004};

    typedef struct packed {
        logic [31:0] awaddr;
        logic awvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic wvalid;
        logic bready;
        logic [31:0] araddr;
        logic arvalid;
        logic rready;
    } axil_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic [1:0] bresp;
        logic bvalid;
        logic arready;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic rvalid;
    } axil_rsp_t;

    localparam axil_rsp_t RSP_RST = '{awready: 1'h1, wready: 1'h1, bresp: 2'h0, bvalid: 1'h0,
        arready: 1'h1, rdata: 32'h0, rresp: 2'h0, rvalid: 1'h0};
endpackage : pwm_pkg
`default_nettype wire

// ==== rtl/pwm_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module pwm_top #(
    parameter int TB0_CYC = pwm_pkg::TB0_NS / pwm_pkg::CLK_NS,
    parameter int TB1_CYC = pwm_pkg::TB1_NS / pwm_pkg::CLK_NS,
    parameter int TB2_CYC = pwm_pkg::TB2_NS / pwm_pkg::CLK_NS,
    parameter int TB3_CYC = pwm_pkg::TB3_NS / pwm_pkg::CLK_NS
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic reset_i,
    // Register bus
    input wire pwm_pkg::axil_req_t axi_req_i,
    output pwm_pkg::axil_rsp_t axi_rsp_o,
    // Function inputs
    input wire logic run_trigger_i,
    input wire logic signed [15:0] analog_sample_i,
    input wire logic [15:0] period_live_i,
    // Pulse output
    output logic pulse_o
);
    import pwm_pkg::*;

    function automatic logic signed [15:0] sat_f(input logic signed [31:0] v,
                                                 input logic signed [15:0] lim);
        if (v > 32'(lim)) return lim;
        if (v < -32'(lim)) return -lim;
        return v[15:0];
    endfunction : sat_f

    function automatic logic [31:0] merge_f(input logic [31:0] old, input logic [31:0] d,
                                            input logic [3:0] s);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) r[8*i +: 8] = d[8*i +: 8];
        end
        return r;
    endfunction : merge_f

    function automatic logic signed [31:0] work_f(input logic signed [15:0] a,
                                                  input logic signed [15:0] g,
                                                  input logic signed [15:0] o);
        logic signed [31:0] p;
        p = (32'(a) * 32'(g)) / GAIN_SCALE;
        return p + 32'(o);
    endfunction : work_f

    function automatic logic [PRE_W-1:0] tb_last_f(input logic [1:0] tb);
        case (tb)
            2'h0: return PRE_W'(TB0_CYC - 1);
            2'h1: return PRE_W'(TB1_CYC - 1);
            2'h2: return PRE_W'(TB2_CYC - 1);
            default: return PRE_W'(TB3_CYC - 1);
        endcase
    endfunction : tb_last_f

    // Register bus state
    axil_rsp_t rsp_r, rsp_nxt;
    cfg_t cfg_r, cfg_nxt;
    logic [7:0] aw_addr_r, aw_addr_nxt;
    logic aw_held_r, aw_held_nxt;
    logic [31:0] w_data_r, w_data_nxt;
    logic [3:0] w_strb_r, w_strb_nxt;
    logic w_held_r, w_held_nxt;
    logic [31:0] wv;

    // Datapath state
    run_st_t st_r, st_nxt;
    logic trig_d_r;
    logic signed [31:0] work_r;
    logic kick_r, start_r, start_nxt;
    duty_cls_t cls_r, cls_nxt;
    logic [15:0] cap_per_r, cap_per_nxt;
    logic [15:0] num_r, num_nxt;
    logic [15:0] span_r, span_nxt;
    logic [15:0] duty_r, duty_nxt;
    logic [15:0] dper_r, dper_nxt;
    logic duty_ok_r, duty_ok_nxt;
    logic [PRE_W-1:0] pre_r, pre_nxt;
    logic [15:0] tick_r, tick_nxt;
    logic [15:0] per_r, per_nxt;
    logic [15:0] high_r, high_nxt;
    logic pulse_r, pulse_nxt;
    logic trig_rise;
    logic div_done;
    logic [15:0] quot;

    assign trig_rise = run_trigger_i && !trig_d_r;

    always_comb begin
        rsp_nxt = rsp_r;
        cfg_nxt = cfg_r;
        aw_addr_nxt = aw_addr_r;
        aw_held_nxt = aw_held_r;
        w_data_nxt = w_data_r;
        w_strb_nxt = w_strb_r;
        w_held_nxt = w_held_r;
        wv = '0;
        if (axi_req_i.awvalid && rsp_r.awready) begin
            aw_held_nxt = 1'b1;
            aw_addr_nxt = axi_req_i.awaddr[31:8] == '0 ? axi_req_i.awaddr[7:0] : 8'hff;
        end
        if (axi_req_i.wvalid && rsp_r.wready) begin
            w_held_nxt = 1'b1;
            w_data_nxt = axi_req_i.wdata;
            w_strb_nxt = axi_req_i.wstrb;
        end
        if (rsp_r.bvalid && axi_req_i.bready) rsp_nxt.bvalid = 1'b0;
        if (aw_held_nxt && w_held_nxt && !rsp_r.bvalid) begin
            aw_held_nxt = 1'b0;
            w_held_nxt = 1'b0;
            rsp_nxt.bvalid = 1'b1;
            rsp_nxt.bresp = RESP_OKAY;
            case (aw_addr_nxt)
                ADR_CTRL: begin
                    wv = merge_f({26'h0, cfg_r.dec, 1'b0, cfg_r.tb, cfg_r.src}, w_data_nxt, w_strb_nxt);
                    cfg_nxt.src = wv[CTRL_SRC_B];
                    cfg_nxt.tb = wv[CTRL_TB_LSB +: 2];
                    cfg_nxt.dec = wv[CTRL_DEC_LSB +: 2] & DEC_MAX;
                end
                ADR_GAIN: cfg_nxt.gain = sat_f(merge_f(32'(cfg_r.gain), w_data_nxt, w_strb_nxt), GAIN_MAX);
                ADR_OFFSET: cfg_nxt.offset = sat_f(merge_f(32'(cfg_r.offset), w_data_nxt, w_strb_nxt), OFFS_MAX);
                ADR_LO: cfg_nxt.lo = sat_f(merge_f(32'(cfg_r.lo), w_data_nxt, w_strb_nxt), LIM_MAX);
                ADR_HI: cfg_nxt.hi = sat_f(merge_f(32'(cfg_r.hi), w_data_nxt, w_strb_nxt), LIM_MAX);
                ADR_PERIOD: begin
                    wv = merge_f({16'h0, cfg_r.period}, w_data_nxt, w_strb_nxt);
                    cfg_nxt.period = wv[15:0];
                end
                ADR_STATUS, ADR_WORK: rsp_nxt.bresp = RESP_OKAY;
                default: rsp_nxt.bresp = RESP_SLVERR;
            endcase
        end
        rsp_nxt.awready = !aw_held_nxt && !rsp_nxt.bvalid;
        rsp_nxt.wready = !w_held_nxt && !rsp_nxt.bvalid;
        if (rsp_r.rvalid && axi_req_i.rready) rsp_nxt.rvalid = 1'b0;
        if (axi_req_i.arvalid && rsp_r.arready) begin
            rsp_nxt.rvalid = 1'b1;
            rsp_nxt.rresp = RESP_OKAY;
            rsp_nxt.rdata = '0;
            case (axi_req_i.araddr[31:8] == '0 ? axi_req_i.araddr[7:0] : 8'hff)
                ADR_CTRL: rsp_nxt.rdata = {26'h0, cfg_r.dec, 1'b0, cfg_r.tb, cfg_r.src};
                ADR_GAIN: rsp_nxt.rdata = 32'(cfg_r.gain);
                ADR_OFFSET: rsp_nxt.rdata = 32'(cfg_r.offset);
                ADR_LO: rsp_nxt.rdata = 32'(cfg_r.lo);
                ADR_HI: rsp_nxt.rdata = 32'(cfg_r.hi);
                ADR_PERIOD: rsp_nxt.rdata = {16'h0, cfg_r.period};
                ADR_STATUS: begin
                    rsp_nxt.rdata[STAT_PULSE_B] = pulse_r;
                    rsp_nxt.rdata[STAT_RUN_B] = st_r == ST_RUN;
                    rsp_nxt.rdata[STAT_VALID_B] = duty_ok_r;
                end
                ADR_WORK: rsp_nxt.rdata = work_r;
                default: rsp_nxt.rresp = RESP_SLVERR;
            endcase
        end
        rsp_nxt.arready = !rsp_nxt.rvalid;
    end

    // Duty is recomputed back to back in the background, so each period
    // picks up the newest result without stalling the output.
    always_comb begin
        start_nxt = !kick_r || div_done;
        cls_nxt = cls_r;
        cap_per_nxt = cap_per_r;
        num_nxt = num_r;
        span_nxt = span_r;
        duty_nxt = duty_r;
        dper_nxt = dper_r;
        duty_ok_nxt = duty_ok_r;
        if (start_nxt) begin
            cap_per_nxt = cfg_r.src ? period_live_i : cfg_r.period;
            num_nxt = 16'(work_r - 32'(cfg_r.lo));
            span_nxt = 16'(32'(cfg_r.hi) - 32'(cfg_r.lo));
            if (work_r <= 32'(cfg_r.lo)) cls_nxt = CLS_LOW;
            else if (work_r >= 32'(cfg_r.hi)) cls_nxt = CLS_FULL;
            else cls_nxt = CLS_MID;
        end
        if (div_done) begin
            case (cls_r)
                CLS_MID: duty_nxt = quot;
                CLS_FULL: duty_nxt = cap_per_r;
                default: duty_nxt = '0;
            endcase
            dper_nxt = cap_per_r;
            duty_ok_nxt = 1'b1;
        end
        if (st_r == ST_IDLE && trig_rise) duty_ok_nxt = 1'b0;
    end

    duty_div u_div (
        .sys_clk_i(sys_clk_i),
        .reset_i(reset_i),
        .start_i(start_r),
        .dividend_i(cls_r == CLS_MID ? 32'(num_r) * 32'(cap_per_r) : 32'h0),
        .divisor_i(cls_r == CLS_MID ? span_r : 16'h0001),
        .done_o(div_done),
        .quot_o(quot)
    );

    always_comb begin
        st_nxt = st_r;
        pre_nxt = pre_r;
        tick_nxt = tick_r;
        per_nxt = per_r;
        high_nxt = high_r;
        case (st_r)
            ST_IDLE: if (trig_rise) st_nxt = ST_CALC;
            ST_CALC: begin
                if (!run_trigger_i) st_nxt = ST_IDLE;
                else if (duty_ok_r) begin
                    st_nxt = ST_RUN;
                    pre_nxt = '0;
                    tick_nxt = '0;
                    per_nxt = dper_r;
                    high_nxt = duty_r;
                end
            end
            ST_RUN: begin
                if (!run_trigger_i) st_nxt = ST_IDLE;
                else if (pre_r >= tb_last_f(cfg_r.tb)) begin
                    pre_nxt = '0;
                    if (17'(tick_r) + 17'h1 >= 17'(per_r)) begin
                        tick_nxt = '0;
                        per_nxt = dper_r;
                        high_nxt = duty_r;
                    end else begin
                        tick_nxt = tick_r + 16'h0001;
                    end
                end else begin
                    pre_nxt = pre_r + PRE_W'(1);
                end
            end
            default: st_nxt = ST_IDLE;
        endcase
        pulse_nxt = st_nxt == ST_RUN && tick_nxt < high_nxt;
    end

    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            rsp_r <= RSP_RST;
            cfg_r <= CFG_RST;
            aw_addr_r <= '0;
            aw_held_r <= 1'b0;
            w_data_r <= '0;
            w_strb_r <= '0;
            w_held_r <= 1'b0;
            st_r <= ST_IDLE;
            trig_d_r <= 1'b0;
            work_r <= '0;
            kick_r <= 1'b0;
            start_r <= 1'b0;
            cls_r <= CLS_LOW;
            cap_per_r <= '0;
            num_r <= '0;
            span_r <= '0;
            duty_r <= '0;
            dper_r <= '0;
            duty_ok_r <= 1'b0;
            pre_r <= '0;
            tick_r <= '0;
            per_r <= '0;
            high_r <= '0;
            pulse_r <= 1'b0;
        end else begin
            rsp_r <= rsp_nxt;
            cfg_r <= cfg_nxt;
            aw_addr_r <= aw_addr_nxt;
            aw_held_r <= aw_held_nxt;
            w_data_r <= w_data_nxt;
            w_strb_r <= w_strb_nxt;
            w_held_r <= w_held_nxt;
            st_r <= st_nxt;
            trig_d_r <= run_trigger_i;
            work_r <= work_f(analog_sample_i, cfg_r.gain, cfg_r.offset);
            kick_r <= 1'b1;
            start_r <= start_nxt;
            cls_r <= cls_nxt;
            cap_per_r <= cap_per_nxt;
            num_r <= num_nxt;
            span_r <= span_nxt;
            duty_r <= duty_nxt;
            dper_r <= dper_nxt;
            duty_ok_r <= duty_ok_nxt;
            pre_r <= pre_nxt;
            tick_r <= tick_nxt;
            per_r <= per_nxt;
            high_r <= high_nxt;
            pulse_r <= pulse_nxt;
        end
    end

    assign axi_rsp_o = rsp_r;
    assign pulse_o = pulse_r;

    default clocking dc @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);

    sequence rise_s;
        run_trigger_i && !trig_d_r && st_r == ST_IDLE;
    endsequence
    sequence wrap_s;
        st_r == ST_RUN && run_trigger_i && pre_r >= tb_last_f(cfg_r.tb) && 17'(tick_r) + 17'h1 >= 17'(per_r);
    endsequence

    level_no_start_a: assert property (st_r == ST_IDLE && !(run_trigger_i && !trig_d_r) |=> st_r == ST_IDLE)
        else $error("left idle without a trigger edge");
    rise_calc_a: assert property (rise_s |=> st_r == ST_CALC)
        else $error("trigger edge did not start");
    low_quiet_a: assert property (!run_trigger_i |=> !pulse_o && st_r == ST_IDLE)
        else $error("output active with trigger low");
    gain_range_a: assert property (cfg_r.gain <= GAIN_MAX && cfg_r.gain >= -GAIN_MAX)
        else $error("gain out of range");
    offs_range_a: assert property (cfg_r.offset <= OFFS_MAX && cfg_r.offset >= -OFFS_MAX)
        else $error("offset out of range");
    lim_range_a: assert property (cfg_r.lo <= LIM_MAX && cfg_r.lo >= -LIM_MAX
        && cfg_r.hi <= LIM_MAX && cfg_r.hi >= -LIM_MAX)
        else $error("limit out of range");
    work_calc_a: assert property (1'b1 |=> work_r ==
        work_f($past(analog_sample_i), $past(cfg_r.gain), $past(cfg_r.offset)))
        else $error("working value wrong");
    // Class is recaptured on the same edge, so judge by the old one
    clamp_duty_a: assert property (div_done && cls_r != CLS_MID |=>
        duty_r == ($past(cls_r) == CLS_FULL ? $past(cap_per_r) : 16'h0))
        else $error("clamped duty wrong");
    mid_class_a: assert property (start_r && cls_r == CLS_MID |-> num_r < span_r)
        else $error("mid class outside limits");
    period_wrap_a: assert property (wrap_s |=> st_r == ST_RUN && tick_r == 16'h0
        && pulse_o == (high_r != 16'h0))
        else $error("period did not restart");
    src_sel_a: assert property (start_nxt && cfg_r.src |=> cap_per_r == $past(period_live_i))
        else $error("live period not taken");
endmodule : pwm_top
`default_nettype wire

// ==== testbench/analog_partner.sv ====
`timescale 1ns/1ps
`default_nettype none
module analog_partner (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic reset_i,
    // Values requested by the bench
    input wire logic signed [15:0] sample_set_i,
    input wire logic [15:0] period_set_i,
    // Digital load side
    input wire logic pulse_i,
    output logic signed [15:0] analog_sample_o,
    output logic [15:0] period_live_o,
    output logic [15:0] rises_o
);
    logic pulse_d;

    // Source values change only at clock edges, like a scanned function output
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            analog_sample_o <= 16'sh0000;
            period_live_o <= 16'h0000;
            pulse_d <= 1'b0;
            rises_o <= 16'h0000;
        end else begin
            analog_sample_o <= sample_set_i;
            period_live_o <= period_set_i;
            pulse_d <= pulse_i;
            if (pulse_i && !pulse_d) begin
                rises_o <= rises_o + 16'h0001;
            end
        end
    end
endmodule : analog_partner
`default_nettype wire

// ==== testbench/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
    import pwm_pkg::*;
    typedef struct {
        logic [31:0] ctrl;
        int gain;
        int offs;
        int samp;
        int lo;
        int hi;
        int per;
        int live;
    } case_t;
    localparam int TBC [4] = '{2, 3, 4, 5};
    logic sys_clk_i;
    logic reset_i;
    axil_req_t axi_req;
    axil_rsp_t axi_rsp;
    logic run_trigger;
    logic signed [15:0] analog_sample;
    logic [15:0] period_live;
    logic pulse;
    logic signed [15:0] samp_set;
    logic [15:0] per_set;
    logic [15:0] rises;
    int n_errors;
    int num_checks;
    case_t cases [8];
    logic [7:0] ra [7];
    logic [31:0] rv [7];
    logic [31:0] d;
    logic [1:0] r;

    pwm_top #(.TB0_CYC(2), .TB1_CYC(3), .TB2_CYC(4), .TB3_CYC(5)) dut (
        .sys_clk_i(sys_clk_i), .reset_i(reset_i), .axi_req_i(axi_req), .axi_rsp_o(axi_rsp),
        .run_trigger_i(run_trigger), .analog_sample_i(analog_sample), .period_live_i(period_live),
        .pulse_o(pulse));
    analog_partner partner (
        .sys_clk_i(sys_clk_i), .reset_i(reset_i), .sample_set_i(samp_set), .period_set_i(per_set),
        .pulse_i(pulse), .analog_sample_o(analog_sample), .period_live_o(period_live), .rises_o(rises));

    initial begin
        sys_clk_i = 1'b0;
        forever #20 sys_clk_i = ~sys_clk_i;
    end

    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
        int i;
        logic aw;
        logic w;
        @(posedge sys_clk_i);
        axi_req.awaddr <= {24'h0, a};
        axi_req.wdata <= v;
        axi_req.wstrb <= 4'hf;
        axi_req.awvalid <= 1'b1;
        axi_req.wvalid <= 1'b1;
        axi_req.bready <= 1'b1;
        aw = 1'b1;
        w = 1'b1;
        for (i = 0; i < 100; i++) begin
            @(posedge sys_clk_i);
            if (axi_rsp.bvalid === 1'b1) begin
                resp = axi_rsp.bresp;
                axi_req.bready <= 1'b0;
                break;
            end
            if (aw && axi_rsp.awready === 1'b1) begin
                aw = 1'b0;
                axi_req.awvalid <= 1'b0;
            end
            if (w && axi_rsp.wready === 1'b1) begin
                w = 1'b0;
                axi_req.wvalid <= 1'b0;
            end
        end
        if (i == 100) begin
            n_errors++;
            stop_test();
        end
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
        int i;
        logic ar;
        @(posedge sys_clk_i);
        axi_req.araddr <= {24'h0, a};
        axi_req.arvalid <= 1'b1;
        axi_req.rready <= 1'b1;
        ar = 1'b1;
        for (i = 0; i < 100; i++) begin
            @(posedge sys_clk_i);
            if (axi_rsp.rvalid === 1'b1) begin
                v = axi_rsp.rdata;
                resp = axi_rsp.rresp;
                axi_req.rready <= 1'b0;
                break;
            end
            if (ar && axi_rsp.arready === 1'b1) begin
                ar = 1'b0;
                axi_req.arvalid <= 1'b0;
            end
        end
        if (i == 100) begin
            n_errors++;
            stop_test();
        end
    endtask : axi_rd

    task automatic run_case(input case_t c);
        logic [31:0] v;
        logic [31:0] m;
        logic [1:0] rs;
        int work, h, p, tc, i, hc;
        logic [15:0] r0;
        @(posedge sys_clk_i);
        run_trigger <= 1'b0;
        repeat (2) @(negedge sys_clk_i);
        chk("pulse idle", 32'h0, {31'h0, pulse});
        axi_wr(ADR_CTRL, c.ctrl, rs);
        axi_wr(ADR_GAIN, c.gain, rs);
        axi_wr(ADR_OFFSET, c.offs, rs);
        axi_wr(ADR_LO, c.lo, rs);
        axi_wr(ADR_HI, c.hi, rs);
        axi_wr(ADR_PERIOD, c.per, rs);
        samp_set <= c.samp[15:0];
        per_set <= c.live[15:0];
        // Background divide must have captured the new settings before the edge
        repeat (40) @(posedge sys_clk_i);
        work = c.samp * c.gain / GAIN_SCALE + c.offs;
        axi_rd(ADR_WORK, v, rs);
        chk("working value", work, v);
        p = c.ctrl[0] ? c.live : c.per;
        tc = TBC[c.ctrl[2:1]];
        h = (work <= c.lo) ? 0 : (work >= c.hi) ? p : (work - c.lo) * p / (c.hi - c.lo);
        run_trigger <= 1'b1;
        for (i = 0; i < 200; i++) begin
            @(negedge sys_clk_i);
            if (pulse === 1'b1) break;
        end
        if (i == 200 && h != 0) begin
            n_errors++;
            stop_test();
        end
        r0 = rises;
        hc = 0;
        // Window of three whole periods, aligned to the first rising edge
        for (i = 0; i < 3 * p * tc; i++) begin
            @(negedge sys_clk_i);
            if (pulse === 1'b1) hc++;
        end
        chk("high cycles", 3 * h * tc, hc);
        // A full-high train rises only once, at its start
        chk("rises", (h == 0) ? 0 : (h < p) ? 3 : 1, rises - r0);
        m = (32'h1 << STAT_RUN_B) | (32'h1 << STAT_VALID_B);
        axi_rd(ADR_STATUS, v, rs);
        chk("status running", m, v & m);
    endtask : run_case

    initial begin
        axi_req = '0;
        run_trigger = 1'b0;
        samp_set = 16'sh0000;
        per_set = 16'h0000;
        n_errors = 0;
        num_checks = 0;
        reset_i = 1'b1;
        repeat (12) @(posedge sys_clk_i);
        reset_i <= 1'b0;
        ra = '{ADR_CTRL, ADR_GAIN, ADR_OFFSET, ADR_LO, ADR_HI, ADR_PERIOD, ADR_STATUS};
        rv = '{32'h0, 32'h64, 32'h0, 32'h0, 32'h3e8, 32'h4, 32'h0};
        for (int k = 0; k < 7; k++) begin
            axi_rd(ra[k], d, r);
            chk("reset value", rv[k], d);
        end
        $display("test reset values done");
        // Out-of-range writes saturate to the legal limits
        ra[0:4] = '{ADR_GAIN, ADR_GAIN, ADR_OFFSET, ADR_LO, ADR_HI};
        rv[0:4] = '{32'h7d0, 32'hfffff830, 32'h4e20, 32'hffff8ad0, 32'h7530};
        cases[0:4] = '{'{0, 1000, 0, 0, 0, 0, 0, 0}, '{0, -1000, 0, 0, 0, 0, 0, 0}, '{0, 10000, 0, 0, 0, 0, 0, 0},
            '{0, -20000, 0, 0, 0, 0, 0, 0}, '{0, 20000, 0, 0, 0, 0, 0, 0}};
        for (int k = 0; k < 5; k++) begin
            axi_wr(ra[k], rv[k], r);
            axi_rd(ra[k], d, r);
            chk("saturated value", cases[k].gain, d);
        end
        $display("test saturation done");
        axi_wr(8'h20, 32'h1, r);
        chk("unmapped bresp", RESP_SLVERR, r);
        axi_rd(8'h20, d, r);
        chk("unmapped rresp", RESP_SLVERR, r);
        chk("unmapped rdata", 32'h0, d);
        axi_wr(ADR_STATUS, 32'hffffffff, r);
        chk("status write bresp", RESP_OKAY, r);
        $display("test unmapped done");
        cases = '{'{32'h00, 100, 0, 500, 0, 1000, 4, 9}, '{32'h02, 100, 0, 300, 0, 1000, 10, 9},
            '{32'h34, 150, 100, 200, 0, 1000, 5, 9}, '{32'h06, 100, 0, -100, -500, 500, 4, 9},
            '{32'h00, 100, 0, 0, 0, 1000, 4, 9}, '{32'h00, 100, 0, 1200, 0, 1000, 4, 9},
            '{32'h01, 100, 0, 500, 0, 1000, 4, 6}, '{32'h00, -200, 0, -300, 0, 1000, 5, 9}};
        for (int k = 0; k < 8; k++) begin
            run_case(cases[k]);
            $display("test pulse case %0d done", k);
        end
        stop_test();
    end
endmodule : tb
`default_nettype wire
